// file: rtl/drive_ramp_pkg.sv
// shared offsets, encodings, limits and carriers of the ramp parameter bank
package drive_ramp_pkg;
	// bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int IDX_W = 7;
	localparam int FREQ_W = 17;
	localparam int SRC_N = 8;

	// register offsets (word addresses)
	localparam logic [15:0] OFS_BASE = 16'h1274;
	localparam logic [15:0] OFS_ACC_T_HI = 16'h1274;
	localparam logic [15:0] OFS_ACC_T_LO = 16'h1275;
	localparam logic [15:0] OFS_DEC_T_HI = 16'h1276;
	localparam logic [15:0] OFS_DEC_T_LO = 16'h1277;
	localparam logic [15:0] OFS_RAMP_SEL = 16'h1278;
	localparam logic [15:0] OFS_ACC_F_HI = 16'h1279;
	localparam logic [15:0] OFS_ACC_F_LO = 16'h127a;
	localparam logic [15:0] OFS_DEC_F_HI = 16'h127b;
	localparam logic [15:0] OFS_DEC_F_LO = 16'h127c;
	localparam logic [15:0] OFS_ACC_PAT = 16'h127d;
	localparam logic [15:0] OFS_DEC_PAT = 16'h127e;
	localparam logic [15:0] OFS_CI_SF_HI = 16'h1281;
	localparam logic [15:0] OFS_CI_SF_LO = 16'h1282;
	localparam logic [15:0] OFS_CI_EF_HI = 16'h1283;
	localparam logic [15:0] OFS_CI_EF_LO = 16'h1284;
	localparam logic [15:0] OFS_CI_SR = 16'h1285;
	localparam logic [15:0] OFS_CI_ER = 16'h1286;
	localparam logic [15:0] OFS_CI_SEL = 16'h1287;
	localparam logic [15:0] OFS_ACC_CURV = 16'h12a5;
	localparam logic [15:0] OFS_DEC_CURV = 16'h12a6;
	localparam logic [15:0] OFS_SRC_ONE = 16'h12af;
	localparam logic [15:0] OFS_SRC_TWO = 16'h12b0;
	localparam logic [15:0] OFS_SRC_OP = 16'h12b1;
	localparam logic [15:0] OFS_OFF_HI = 16'h12b3;
	localparam logic [15:0] OFS_OFF_LO = 16'h12b4;
	localparam logic [15:0] OFS_OFF_SIGN = 16'h12b5;
	localparam logic [15:0] OFS_XS_A1 = 16'h12b9;
	localparam logic [15:0] OFS_XS_A2 = 16'h12ba;
	localparam logic [15:0] OFS_XS_D1 = 16'h12bb;
	localparam logic [15:0] OFS_XS_D2 = 16'h12bc;
	localparam logic [15:0] OFS_STOP_F_HI = 16'h12bd;
	localparam logic [15:0] OFS_STOP_F_LO = 16'h12be;
	localparam logic [15:0] OFS_STOP_T = 16'h12bf;
	localparam logic [15:0] OFS_SLP_HI = 16'h12c0;
	localparam logic [15:0] OFS_SLP_LO = 16'h12c1;
	localparam logic [15:0] OFS_SLP_DLY = 16'h12c2;
	localparam logic [15:0] OFS_STATUS = 16'h1400;

	// array indexes of registers the datapath reads, and of the time low words that reset loads
	localparam logic [IDX_W-1:0] IDX_RAMP_SEL = 7'h04;
	localparam logic [IDX_W-1:0] IDX_ACC_PAT = 7'h09;
	localparam logic [IDX_W-1:0] IDX_DEC_PAT = 7'h0a;
	localparam logic [IDX_W-1:0] IDX_ACC_CURV = 7'h31;
	localparam logic [IDX_W-1:0] IDX_DEC_CURV = 7'h32;
	localparam logic [IDX_W-1:0] IDX_SRC_ONE = 7'h3b;
	localparam logic [IDX_W-1:0] IDX_SRC_TWO = 7'h3c;
	localparam logic [IDX_W-1:0] IDX_SRC_OP = 7'h3d;
	localparam logic [IDX_W-1:0] IDX_OFF_HI = 7'h3f;
	localparam logic [IDX_W-1:0] IDX_OFF_LO = 7'h40;
	localparam logic [IDX_W-1:0] IDX_OFF_SIGN = 7'h41;
	localparam logic [IDX_W-1:0] IDX_ACC_T_LO = 7'h01;
	localparam logic [IDX_W-1:0] IDX_DEC_T_LO = 7'h03;

	// value limits
	localparam logic [31:0] TIME_MIN = 32'h0000_0001;
	localparam logic [31:0] TIME_MAX = 32'h0005_7e40;
	localparam logic [31:0] FREQ_MAX = 32'h0001_86a0;
	localparam logic [15:0] RAMP_SEL_MAX = 16'h0002;
	localparam logic [15:0] PAT_MAX = 16'h0004;
	localparam logic [15:0] CURV_MIN = 16'h0001;
	localparam logic [15:0] CURV_MAX = 16'h000a;
	localparam logic [15:0] SRC_MAX = 16'h0007;
	localparam logic [15:0] SRC_HOLE = 16'h0006;
	localparam logic [15:0] OP_MAX = 16'h0002;
	localparam logic [15:0] FLAG_MAX = 16'h0001;
	localparam logic [15:0] RATIO_MAX = 16'h0064;
	localparam logic [15:0] XS_MAX = 16'h0032;
	localparam logic [15:0] STOP_T_MAX = 16'h0258;
	localparam logic [15:0] SLP_DLY_MAX = 16'h00ff;

	// reset values
	localparam logic [15:0] RST_TIME_LO = 16'h03e8;
	localparam logic [15:0] RST_CURV = 16'h0002;
	localparam logic [31:0] RST_TIME = 32'h0000_03e8;

	// multiply result rescale back to 0.01 Hz
	localparam int MUL_DIV = 100;

	// status bit positions
	localparam int ST_REJECT = 0;

	typedef enum logic [1:0] {
		RAMP_BY_TERMINAL = 2'h0,
		RAMP_BY_FREQ = 2'h1,
		RAMP_BY_DIR = 2'h2
	} ramp_sel_t;

	typedef enum logic [2:0] {
		PAT_LINEAR = 3'h0,
		PAT_S = 3'h1,
		PAT_U = 3'h2,
		PAT_INV_U = 3'h3,
		PAT_EXT_S = 3'h4
	} pattern_t;

	typedef enum logic [2:0] {
		SRC_PANEL = 3'h0,
		SRC_POT = 3'h1,
		SRC_VOLTAGE = 3'h2,
		SRC_CURRENT = 3'h3,
		SRC_SERIAL = 3'h4,
		SRC_OPTION = 3'h5,
		SRC_PULSE = 3'h7
	} src_t;

	typedef enum logic [1:0] {
		OP_ADD = 2'h0,
		OP_SUB = 2'h1,
		OP_MUL = 2'h2
	} op_t;

	typedef struct packed {
		logic [31:0] accel_time;
		logic [31:0] decel_time;
		ramp_sel_t ramp_sel;
		pattern_t accel_pat;
		pattern_t decel_pat;
		logic [3:0] accel_curv;
		logic [3:0] decel_curv;
	} ramp_cfg_t;

	typedef struct packed {
		src_t src_one;
		src_t src_two;
		op_t op;
		logic [31:0] offset;
		logic subtract;
	} freq_cfg_t;
endpackage

// file: rtl/drive_ramp_param_bank.sv
// ramp and frequency-reference parameter bank with register port
// Behaviour
// - second accel time: split 32-bit, 1..360000
// - second decel time: split 32-bit, 1..360000
// - ramp select: terminal, frequency, direction change
// - accel pattern: linear, S, U, inverted U, extended
// - decel pattern uses accel pattern encoding
// - curvatures accept 1 to 10 only
// - sources codes 0-5 and 7; 6 undefined
// - operator adds, subtracts or multiplies sources
// - offset sign adds or subtracts offset amount
`timescale 1ns/1ps
module drive_ramp_param_bank
	import drive_ramp_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	// candidate source frequencies, 0.01 Hz, indexed by source code
	input wire logic [SRC_N-1:0][FREQ_W-1:0] src_freq_i,
	// decoded settings
	output ramp_cfg_t ramp_cfg_o,
	output freq_cfg_t freq_cfg_o,
	output logic signed [31:0] freq_ref_o,
	output logic reject_o
);
	localparam int REG_N = 2 ** IDX_W;
	localparam int RES_W = 36;

	logic [DATA_W-1:0] store [REG_N];
	logic [31:0] accel_time;
	logic [31:0] decel_time;
	logic reject;
	logic [IDX_W-1:0] idx;
	logic [IDX_W-1:0] prev_idx;
	logic [31:0] pair;
	logic mapped;
	logic legal;
	logic [15:0] hi_lim;
	logic signed [RES_W-1:0] fa;
	logic signed [RES_W-1:0] fb;
	logic signed [RES_W-1:0] prod;
	logic signed [RES_W-1:0] comb_res;
	logic signed [RES_W-1:0] offs;
	logic signed [RES_W-1:0] next_ref;
	logic signed [RES_W-1:0] sat_hi;
	logic signed [RES_W-1:0] sat_lo;

	// index into the flop array; only meaningful while mapped
	assign idx = addr_i[IDX_W-1:0] - OFS_BASE[IDX_W-1:0];
	assign prev_idx = idx - 7'h01;
	assign pair = {store[prev_idx], wdata_i};
	assign hi_lim = FREQ_MAX[31:16];

	// address decode and value check in one table
	always_comb
	begin
		mapped = 1'b1;
		legal = 1'b1;
		case (addr_i)
			OFS_ACC_T_HI, OFS_DEC_T_HI:
				legal = wdata_i <= TIME_MAX[31:16];
			OFS_ACC_T_LO, OFS_DEC_T_LO:
				legal = pair >= TIME_MIN && pair <= TIME_MAX;
			OFS_RAMP_SEL:
				legal = wdata_i <= RAMP_SEL_MAX;
			OFS_ACC_PAT:
				legal = wdata_i <= PAT_MAX;
			OFS_DEC_PAT:
				legal = wdata_i <= PAT_MAX;
			OFS_ACC_CURV, OFS_DEC_CURV:
				legal = wdata_i >= CURV_MIN && wdata_i <= CURV_MAX;
			OFS_SRC_ONE, OFS_SRC_TWO:
				legal = wdata_i <= SRC_MAX && wdata_i != SRC_HOLE;
			OFS_SRC_OP:
				legal = wdata_i <= OP_MAX;
			OFS_OFF_SIGN:
				legal = wdata_i <= FLAG_MAX;
			OFS_CI_SEL:
				legal = wdata_i <= FLAG_MAX;
			OFS_CI_SR, OFS_CI_ER:
				legal = wdata_i <= RATIO_MAX;
			OFS_XS_A1, OFS_XS_A2, OFS_XS_D1, OFS_XS_D2:
				legal = wdata_i <= XS_MAX;
			OFS_STOP_T:
				legal = wdata_i <= STOP_T_MAX;
			OFS_SLP_DLY:
				legal = wdata_i <= SLP_DLY_MAX;
			OFS_ACC_F_HI, OFS_DEC_F_HI, OFS_CI_SF_HI, OFS_CI_EF_HI,
			OFS_OFF_HI, OFS_STOP_F_HI, OFS_SLP_HI:
				legal = wdata_i <= hi_lim;
			OFS_ACC_F_LO, OFS_DEC_F_LO, OFS_CI_SF_LO, OFS_CI_EF_LO,
			OFS_OFF_LO, OFS_STOP_F_LO, OFS_SLP_LO:
				legal = pair <= FREQ_MAX;
			default:
			begin
				// reserved holes and everything outside the bank
				mapped = 1'b0;
				legal = 1'b0;
			end
		endcase
	end

	// register storage; an out-of-range write keeps the old word
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < REG_N; i++)
				store[i] <= 16'h0000;
			store[IDX_ACC_T_LO] <= RST_TIME_LO;
			store[IDX_DEC_T_LO] <= RST_TIME_LO;
			store[IDX_ACC_CURV] <= RST_CURV;
			store[IDX_DEC_CURV] <= RST_CURV;
		end
		else if (wr_i && mapped && legal)
		begin
			store[idx] <= wdata_i;
		end
	end

	// the ramp times move only on a legal low-word write, so a
	// half-written pair never reaches the ramp generator
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			accel_time <= RST_TIME;
			decel_time <= RST_TIME;
		end
		else if (wr_i && legal)
		begin
			if (addr_i == OFS_ACC_T_LO)
				accel_time <= pair;
			if (addr_i == OFS_DEC_T_LO)
				decel_time <= pair;
		end
	end

	// sticky reject flag; a new reject beats a clear in the same cycle
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			reject <= 1'b0;
		else if (wr_i && mapped && !legal)
			reject <= 1'b1;
		else if (wr_i && addr_i == OFS_STATUS && wdata_i[ST_REJECT])
			reject <= 1'b0;
	end

	// read data stand for exactly one cycle after the strobe
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_o <= 16'h0000;
		else if (rd_i && mapped)
			rdata_o <= store[idx];
		else if (rd_i && addr_i == OFS_STATUS)
			rdata_o <= {15'h0000, reject};
		else
			rdata_o <= 16'h0000;
	end

	// settings view straight off the storage flops
	assign ramp_cfg_o.accel_time = accel_time;
	assign ramp_cfg_o.decel_time = decel_time;
	assign ramp_cfg_o.ramp_sel = ramp_sel_t'(store[IDX_RAMP_SEL][1:0]);
	assign ramp_cfg_o.accel_pat = pattern_t'(store[IDX_ACC_PAT][2:0]);
	assign ramp_cfg_o.decel_pat = pattern_t'(store[IDX_DEC_PAT][2:0]);
	assign ramp_cfg_o.accel_curv = store[IDX_ACC_CURV][3:0];
	assign ramp_cfg_o.decel_curv = store[IDX_DEC_CURV][3:0];
	assign freq_cfg_o.src_one = src_t'(store[IDX_SRC_ONE][2:0]);
	assign freq_cfg_o.src_two = src_t'(store[IDX_SRC_TWO][2:0]);
	assign freq_cfg_o.op = op_t'(store[IDX_SRC_OP][1:0]);
	assign freq_cfg_o.offset = {store[IDX_OFF_HI], store[IDX_OFF_LO]};
	assign freq_cfg_o.subtract = store[IDX_OFF_SIGN][0];
	assign reject_o = reject;

	// source selection and combining; code 6 can never be stored,
	// so the unused input slot is never picked
	assign fa = RES_W'(src_freq_i[store[IDX_SRC_ONE][2:0]]);
	assign fb = RES_W'(src_freq_i[store[IDX_SRC_TWO][2:0]]);
	assign prod = (fa * fb) / RES_W'(MUL_DIV);
	assign offs = RES_W'({store[IDX_OFF_HI], store[IDX_OFF_LO]});
	assign sat_hi = RES_W'(32'h7fff_ffff);
	assign sat_lo = -RES_W'(32'h7fff_ffff) - RES_W'(1);

	always_comb
	begin
		case (op_t'(store[IDX_SRC_OP][1:0]))
			OP_ADD: comb_res = fa + fb;
			OP_SUB: comb_res = fa - fb;
			OP_MUL: comb_res = prod;
			default: comb_res = fa + fb;
		endcase
		if (store[IDX_OFF_SIGN][0])
			next_ref = comb_res - offs;
		else
			next_ref = comb_res + offs;
	end

	// saturate rather than wrap, so a large product cannot flip sign
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			freq_ref_o <= 32'sh0000_0000;
		else if (next_ref > sat_hi)
			freq_ref_o <= 32'sh7fff_ffff;
		else if (next_ref < sat_lo)
			freq_ref_o <= 32'sh8000_0000;
		else
			freq_ref_o <= next_ref[31:0];
	end
endmodule // drive_ramp_param_bank

// file: tb/drive_ramp_param_bank_properties.sv
// port checks of the ramp parameter bank
`timescale 1ns/1ps
module drive_ramp_param_bank_properties
	import drive_ramp_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	// settings and datapath
	input wire logic [SRC_N-1:0][FREQ_W-1:0] src_freq_i,
	input wire ramp_cfg_t ramp_cfg_o,
	input wire freq_cfg_t freq_cfg_o,
	input wire logic signed [31:0] freq_ref_o,
	input wire logic reject_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	logic signed [31:0] a_v;
	logic signed [31:0] b_v;
	logic signed [31:0] base_v;
	// expected combination; legal ranges stay clear of saturation
	assign a_v = 32'(src_freq_i[freq_cfg_o.src_one]);
	assign b_v = 32'(src_freq_i[freq_cfg_o.src_two]);
	always_comb
		case (freq_cfg_o.op)
			OP_SUB: base_v = a_v - b_v;
			OP_MUL: base_v = 32'((64'(a_v) * 64'(b_v)) / 64'(MUL_DIV));
			default: base_v = a_v + b_v;
		endcase
	sequence s_wr(logic [15:0] a);
		wr_i && addr_i == a;
	endsequence
	sequence s_hole;
		s_wr(OFS_SRC_ONE) ##0 wdata_i == SRC_HOLE;
	endsequence
	property p_rsv_read; rd_i && addr_i inside {[16'h1288:16'h12a4]} |=> rdata_o == 16'h0000; endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("reserved read not zero");
	property p_hole; s_hole |=> $stable(freq_cfg_o.src_one) && reject_o; endproperty
	a_hole: assert property (p_hole) else $error("undefined source taken");
	property p_ramp_sel; s_wr(OFS_RAMP_SEL) |=> ramp_cfg_o.ramp_sel == ($past(wdata_i) <=
		RAMP_SEL_MAX ? $past(wdata_i[1:0]) : $past(ramp_cfg_o.ramp_sel)); endproperty
	a_ramp_sel: assert property (p_ramp_sel) else $error("ramp select wrong");
	property p_acc_pat; s_wr(OFS_ACC_PAT) |=> ramp_cfg_o.accel_pat == ($past(wdata_i) <= PAT_MAX ?
		$past(wdata_i[2:0]) : $past(ramp_cfg_o.accel_pat)); endproperty
	a_acc_pat: assert property (p_acc_pat) else $error("accel pattern wrong");
	property p_dec_pat; s_wr(OFS_DEC_PAT) |=> ramp_cfg_o.decel_pat == ($past(wdata_i) <= PAT_MAX ?
		$past(wdata_i[2:0]) : $past(ramp_cfg_o.decel_pat)); endproperty
	a_dec_pat: assert property (p_dec_pat) else $error("decel pattern wrong");
	property p_curv; s_wr(OFS_ACC_CURV) |=> ramp_cfg_o.accel_curv == ($past(wdata_i >= CURV_MIN &&
		wdata_i <= CURV_MAX) ? $past(wdata_i[3:0]) : $past(ramp_cfg_o.accel_curv)); endproperty
	a_curv: assert property (p_curv) else $error("curvature wrong");
	property p_add; !freq_cfg_o.subtract |=> freq_ref_o == $past(base_v + freq_cfg_o.offset); endproperty
	a_add: assert property (p_add) else $error("combined reference wrong");
	property p_sign; freq_cfg_o.subtract |=> freq_ref_o == $past(base_v - freq_cfg_o.offset); endproperty
	a_sign: assert property (p_sign) else $error("offset subtract wrong");
endmodule // drive_ramp_param_bank_properties
bind drive_ramp_param_bank drive_ramp_param_bank_properties u_props (.mclk_i, .reset_n_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .src_freq_i, .ramp_cfg_o, .freq_cfg_o, .freq_ref_o, .reject_o);

// file: tb/drive_ramp_param_bank_bench.sv
// self-checking bench for the ramp parameter bank
`timescale 1ns/1ps
module drive_ramp_param_bank_bench
	import drive_ramp_pkg::*;
;
	logic mclk_i;
	logic reset_n_i;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [DATA_W-1:0] rdata_o;
	logic [SRC_N-1:0][FREQ_W-1:0] src_freq_i;
	ramp_cfg_t ramp_cfg_o;
	freq_cfg_t freq_cfg_o;
	logic signed [31:0] freq_ref_o;
	logic reject_o;
	int error_cnt;
	int n_checks;
	int cycles;
	logic [15:0] ev;
	logic [15:0] regs [9] = '{OFS_RAMP_SEL, OFS_ACC_PAT, OFS_DEC_PAT, OFS_ACC_CURV, OFS_DEC_CURV,
		OFS_SRC_ONE, OFS_SRC_TWO, OFS_SRC_OP, OFS_OFF_SIGN};
	drive_ramp_param_bank dut (.mclk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.src_freq_i, .ramp_cfg_o, .freq_cfg_o, .freq_ref_o, .reject_o);
	// 100 MHz clock
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// hang guard, run needs about 510 cycles
	always @(posedge mclk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			error_cnt++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	// one-cycle strobes; the idle cycle after keeps each strobe to one assignment a step
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		chk($sformatf("rdata %h", a), {16'h0000, e}, {16'h0000, rdata_o});
		@(posedge mclk_i);
	endtask
	function automatic logic ok(logic [15:0] a, logic [15:0] v);
		case (a)
			OFS_RAMP_SEL, OFS_SRC_OP: return v <= 16'h0002;
			OFS_ACC_PAT, OFS_DEC_PAT: return v <= 16'h0004;
			OFS_ACC_CURV, OFS_DEC_CURV: return v >= 16'h0001 && v <= 16'h000a;
			OFS_SRC_ONE, OFS_SRC_TWO: return v <= 16'h0007 && v != 16'h0006;
			default: return v <= 16'h0001;
		endcase
	endfunction
	initial
	begin
		reset_n_i <= 1'b0;
		addr_i <= 16'h0000;
		wdata_i <= 16'h0000;
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		for (int i = 0; i < SRC_N; i++)
			src_freq_i[i] <= 17'(i * 1000 + 100);
		repeat (12) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		@(posedge mclk_i);
		rd(OFS_ACC_T_LO, RST_TIME_LO);
		rd(OFS_ACC_CURV, RST_CURV);
		// upper bound kept, one above it refused
		wr(OFS_ACC_T_HI, 16'h0005);
		wr(OFS_ACC_T_LO, 16'h7e40);
		chk("accel_time", 32'h0005_7e40, ramp_cfg_o.accel_time);
		wr(OFS_ACC_T_LO, 16'h7e41);
		chk("accel_time", 32'h0005_7e40, ramp_cfg_o.accel_time);
		chk("reject", 32'h1, {31'h0, reject_o});
		rd(OFS_STATUS, 16'h0001);
		wr(OFS_DEC_T_HI, 16'h0000);
		wr(OFS_DEC_T_LO, 16'h0000);
		chk("decel_time", RST_TIME, ramp_cfg_o.decel_time);
		wr(OFS_DEC_T_LO, 16'h0001);
		chk("decel_time", 32'h0000_0001, ramp_cfg_o.decel_time);
		// reserved places take nothing and raise no flag
		wr(OFS_STATUS, 16'h0001);
		wr(16'h1280, 16'hffff);
		rd(16'h1280, 16'h0000);
		rd(16'h1290, 16'h0000);
		chk("reject", 32'h0, {31'h0, reject_o});
		rd(OFS_STATUS, 16'h0000);
		// sweep every code past its limit
		foreach (regs[k])
		begin
			ev = (regs[k] inside {OFS_ACC_CURV, OFS_DEC_CURV}) ? 16'h0002 : 16'h0000;
			for (int v = 0; v < 12; v++)
			begin
				wr(regs[k], 16'(v));
				if (ok(regs[k], 16'(v)))
					ev = 16'(v);
				rd(regs[k], ev);
			end
		end
		// sources 3 and 1 give 3100 and 1100, offset 500
		wr(OFS_SRC_ONE, 16'h0003);
		wr(OFS_SRC_TWO, 16'h0001);
		wr(OFS_OFF_LO, 16'h01f4);
		for (int op = 0; op < 3; op++)
			for (int sg = 0; sg < 2; sg++)
			begin
				wr(OFS_SRC_OP, 16'(op));
				wr(OFS_OFF_SIGN, 16'(sg));
				ev = (op == 0) ? 16'h1068 : (op == 1) ? 16'h07d0 : 16'h8534;
				#1;
				chk("freq_ref", sg ? ev - 32'h1f4 : ev + 32'h1f4, freq_ref_o);
				@(posedge mclk_i);
			end
		// the offset amount must reach the settings view as written
		chk("offset", 32'h0000_01f4, freq_cfg_o.offset);
		conclude();
	end
endmodule // drive_ramp_param_bank_bench
